// ---- adcrg_cfg.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the ADC register block
// Assumes: Included by its bare name from the rate generator and register modules
// Notes:   Definitions only
`ifndef ADCRG_CFG_SVH
`define ADCRG_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte offsets on the board's register window)
// ----------------------------------------------------------------
`define ADCRG_OFS_GSR 5'h06
`define ADCRG_OFS_PRESCALE 5'h08
`define ADCRG_OFS_PERIOD 5'h0a
`define ADCRG_OFS_IRQ_CTRL 5'h0c
`define ADCRG_OFS_IRQ_LEVEL 5'h0e

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCRG_GSR_RDY_BIT 7
`define ADCRG_GSR_ARMED_BIT 6
`define ADCRG_GSR_RUN_BIT 5
`define ADCRG_GSR_TEST_BIT 2
`define ADCRG_ICR_EN_BIT 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADCRG_RST_PRESCALE 8'h00
`define ADCRG_RST_PERIOD 16'h03e7
`define ADCRG_RST_VECTOR 8'h00
`define ADCRG_RST_IRQ_EN 1'b0

// ----------------------------------------------------------------
// Timing: 50 ns base tick derived from the 10 ns system clock
// ----------------------------------------------------------------
`define ADCRG_BASE_NS 50
`define ADCRG_CLK_NS 10
`define ADCRG_BASE_CYC (`ADCRG_BASE_NS / `ADCRG_CLK_NS)

`endif

// ---- adcrg_pkg.sv ----
// Purpose: Types shared by the ADC register block
// Assumes: adcrg_cfg.svh holds the numbers
// Notes:   Types only
package adcrg_pkg;
   typedef logic [15:0] adcrg_word_type;
   typedef logic [2:0] adcrg_level_type;
   // Register select decoded from the byte offset
   typedef enum logic [2:0] {
      ADCRG_SEL_NONE = 3'b000,
      ADCRG_SEL_GSR = 3'b001,
      ADCRG_SEL_PRE = 3'b010,
      ADCRG_SEL_PER = 3'b011,
      ADCRG_SEL_ICR = 3'b100,
      ADCRG_SEL_ISR = 3'b101
   } adcrg_sel_type;
endpackage

// ---- adcrg_rate_if.sv ----
// Purpose: Carrier between the register file and the sample rate generator
// Assumes: Both ends on i_mclk
// Notes:   Register file drives settings, generator returns the strobe
`timescale 1ns/1ps
interface adcrg_rate_if;
   logic [7:0] prescale;
   logic [15:0] period;
   logic sample_tick;
   modport regs (output prescale, output period, input sample_tick);
   modport gen (input prescale, input period, output sample_tick);
endinterface

// ---- adcrg_rate_gen.sv ----
// Purpose: Three-stage sample clock: 50 ns base, 8-bit prescaler, 16-bit period down-counter
// Assumes: 100 MHz i_mclk, settings held in the register file
// Notes:   New settings take effect only at the period reload
`timescale 1ns/1ps
`include "adcrg_cfg.svh"
module adcrg_rate_gen
   import adcrg_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   adcrg_rate_if.gen rate
);
   localparam logic [2:0] BASE_LAST = 3'(`ADCRG_BASE_CYC - 1);

   logic [2:0] base_cnt, next_base_cnt;
   logic [7:0] pre_cnt, next_pre_cnt;
   logic [7:0] cur_pre, next_cur_pre;
   logic [15:0] per_cnt, next_per_cnt;
   logic tick, next_tick;
   logic base_tick, pre_tick;

   // ----------------------------------------------------------------
   // Counter chain
   // ----------------------------------------------------------------
   // Reloading prescaler with the new value at the period end keeps the
   // two settings coherent; a mid-period write cannot skew one sample
   always_comb begin
      base_tick = (base_cnt == BASE_LAST);
      pre_tick = base_tick && (pre_cnt == 8'h00);
      next_base_cnt = base_tick ? 3'h0 : base_cnt + 3'h1;
      next_pre_cnt = pre_cnt;
      next_cur_pre = cur_pre;
      next_per_cnt = per_cnt;
      next_tick = 1'b0;
      if (base_tick) begin
         next_pre_cnt = (pre_cnt == 8'h00) ? cur_pre : pre_cnt - 8'h01;
      end
      if (pre_tick) begin
         if (per_cnt == 16'h0000) begin
            next_per_cnt = rate.period;
            next_cur_pre = rate.prescale;
            next_pre_cnt = rate.prescale;
            next_tick = 1'b1;
         end else begin
            next_per_cnt = per_cnt - 16'h0001;
         end
      end
   end

   // Register the chain
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         base_cnt <= 3'h0;
         pre_cnt <= `ADCRG_RST_PRESCALE;
         cur_pre <= `ADCRG_RST_PRESCALE;
         per_cnt <= `ADCRG_RST_PERIOD;
         tick <= 1'b0;
      end else begin
         base_cnt <= next_base_cnt;
         pre_cnt <= next_pre_cnt;
         cur_pre <= next_cur_pre;
         per_cnt <= next_per_cnt;
         tick <= next_tick;
      end
   end

   assign rate.sample_tick = tick;

   // ----------------------------------------------------------------
   // Checks: spacing of prescaled ticks and of sample strobes
   // ----------------------------------------------------------------
   logic [31:0] pre_gap, smp_gap, smp_expect;
   logic pre_seen, smp_seen;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pre_gap <= 32'h0;
         smp_gap <= 32'h0;
         smp_expect <= 32'h0;
         pre_seen <= 1'b0;
         smp_seen <= 1'b0;
      end else begin
         pre_gap <= pre_tick ? 32'h1 : pre_gap + 32'h1;
         pre_seen <= pre_seen | pre_tick;
         smp_gap <= tick ? 32'h1 : smp_gap + 32'h1;
         smp_seen <= smp_seen | tick;
         // Captured in the strobe cycle, while the counters still hold the values
         // just loaded, so a later register write cannot skew the expectation
         if (tick) begin
            smp_expect <= (32'(per_cnt) + 32'h1) * (32'(cur_pre) + 32'h1)
                          * 32'(`ADCRG_BASE_CYC);
         end
      end
   end

   property p_prescale_period;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (pre_tick && pre_seen && !$past(tick)) |-> (pre_gap == (32'(cur_pre) + 32'h1) * 32'h5);
   endproperty
   a_prescale_period: assert property (p_prescale_period) else $error("prescale spacing wrong");

   property p_sample_period;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (tick && smp_seen) |-> (smp_gap == smp_expect);
   endproperty
   a_sample_period: assert property (p_sample_period) else $error("sample spacing wrong");

   property p_reload_strobe;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (pre_tick && per_cnt == 16'h0000) |=> (tick && per_cnt == $past(rate.period));
   endproperty
   a_reload_strobe: assert property (p_reload_strobe) else $error("reload missed");
endmodule // adcrg_rate_gen

// ---- adcrg_regs.sv ----
// Purpose: Status, sample clock and interrupt registers of a scanning ADC board
// Assumes: Register port and sequencer events on i_mclk; jumpers are raw pins
// Notes:   16-bit registers at byte offsets; unmapped reads return zero
//
// Contract
// - Data ready set at buffer threshold, cleared by command
// - Armed high until config change or trigger
// - Running set on trigger, cleared on end/abort
// - Status bit 2 shows self-test disable jumper
// - Prescaled clock feeds the sample rate counter
// - Prescaled period is (prescale+1) times 50 ns
// - Sample period (period+1)(prescale+1)50 ns, reset 0x3e7
// - No interrupt request unless enable bit set
// - Vector returned during interrupt acknowledge cycle
// - Jumpered interrupt level readable, read-only
// - Half-full select picks threshold; one-sample always
`timescale 1ns/1ps
`include "adcrg_cfg.svh"
module adcrg_regs
   import adcrg_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Register port
   input wire logic i_reg_sel,
   input wire logic i_reg_wr,
   input wire logic [4:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   output logic o_reg_ack,
   // Buffer and scan sequencer events
   input wire logic i_half_full_select,
   input wire logic i_one_sample_buf,
   input wire logic i_sample_stored,
   input wire logic i_buf_half_evt,
   input wire logic i_buf_full_evt,
   input wire logic i_clear_flag_cmd,
   input wire logic i_scan_arm,
   input wire logic i_cfg_change,
   input wire logic i_trigger,
   input wire logic i_scan_done,
   input wire logic i_abort_cmd,
   // Jumper pins
   input wire logic i_selftest_off_jmp,
   input wire logic [2:0] i_irq_level_jmp,
   // Interrupt request and acknowledge
   input wire logic i_iack_cycle,
   input wire logic [2:0] i_iack_level,
   output logic o_irq_req,
   output logic [2:0] o_irq_level,
   output logic o_iack_ack,
   output logic [7:0] o_iack_vector,
   // Sample strobe
   output logic o_sample_tick
);
   adcrg_rate_if rate ();

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic adcrg_sel_type decode(input logic [4:0] addr);
      adcrg_sel_type s;
      s = ADCRG_SEL_NONE;
      if (addr == `ADCRG_OFS_GSR) begin
         s = ADCRG_SEL_GSR;
      end else if (addr == `ADCRG_OFS_PRESCALE) begin
         s = ADCRG_SEL_PRE;
      end else if (addr == `ADCRG_OFS_PERIOD) begin
         s = ADCRG_SEL_PER;
      end else if (addr == `ADCRG_OFS_IRQ_CTRL) begin
         s = ADCRG_SEL_ICR;
      end else if (addr == `ADCRG_OFS_IRQ_LEVEL) begin
         s = ADCRG_SEL_ISR;
      end
      return s;
   endfunction

   adcrg_sel_type sel;
   logic wr_pre, wr_per, wr_icr;
   always_comb begin
      sel = decode(i_reg_addr);
      wr_pre = i_reg_sel && i_reg_wr && (sel == ADCRG_SEL_PRE);
      wr_per = i_reg_sel && i_reg_wr && (sel == ADCRG_SEL_PER);
      wr_icr = i_reg_sel && i_reg_wr && (sel == ADCRG_SEL_ICR);
   end

   // ----------------------------------------------------------------
   // Jumper synchronisers
   // ----------------------------------------------------------------
   logic [3:0] jmp_meta, jmp_sync;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         jmp_meta <= 4'h0;
         jmp_sync <= 4'h0;
      end else begin
         jmp_meta <= {i_selftest_off_jmp, i_irq_level_jmp};
         jmp_sync <= jmp_meta;
      end
   end
   logic selftest_off_flag;
   adcrg_level_type irq_level;
   assign selftest_off_flag = jmp_sync[3];
   assign irq_level = jmp_sync[2:0];

   // ----------------------------------------------------------------
   // Writable settings
   // ----------------------------------------------------------------
   logic [7:0] prescale_value, next_prescale_value;
   logic [15:0] period_value, next_period_value;
   logic [7:0] irq_vector, next_irq_vector;
   logic irq_enable, next_irq_enable;

   // Reserved bits are dropped on write so they always read back zero
   always_comb begin
      next_prescale_value = prescale_value;
      next_period_value = period_value;
      next_irq_vector = irq_vector;
      next_irq_enable = irq_enable;
      if (wr_pre) begin
         next_prescale_value = i_reg_wdata[7:0];
      end
      if (wr_per) begin
         next_period_value = i_reg_wdata;
      end
      if (wr_icr) begin
         next_irq_vector = i_reg_wdata[7:0];
         next_irq_enable = i_reg_wdata[`ADCRG_ICR_EN_BIT];
      end
   end

   // Register the settings
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         prescale_value <= `ADCRG_RST_PRESCALE;
         period_value <= `ADCRG_RST_PERIOD;
         irq_vector <= `ADCRG_RST_VECTOR;
         irq_enable <= `ADCRG_RST_IRQ_EN;
      end else begin
         prescale_value <= next_prescale_value;
         period_value <= next_period_value;
         irq_vector <= next_irq_vector;
         irq_enable <= next_irq_enable;
      end
   end

   assign rate.prescale = prescale_value;
   assign rate.period = period_value;

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   logic data_ready, next_data_ready;
   logic armed, next_armed;
   logic scan_running_flag, next_scan_running_flag;
   logic rdy_evt;

   // Each flag: the setting event wins over a clear in the same cycle,
   // so a threshold hit is never lost against a racing clear command
   always_comb begin
      if (i_one_sample_buf) begin
         rdy_evt = i_sample_stored;
      end else if (i_half_full_select) begin
         rdy_evt = i_buf_half_evt;
      end else begin
         rdy_evt = i_buf_full_evt;
      end
      next_data_ready = rdy_evt ? 1'b1 : (i_clear_flag_cmd ? 1'b0 : data_ready);
      if (i_scan_arm) begin
         next_armed = 1'b1;
      end else if (i_cfg_change || i_trigger) begin
         next_armed = 1'b0;
      end else begin
         next_armed = armed;
      end
      if (i_trigger) begin
         next_scan_running_flag = 1'b1;
      end else if (i_scan_done || i_abort_cmd) begin
         next_scan_running_flag = 1'b0;
      end else begin
         next_scan_running_flag = scan_running_flag;
      end
   end

   // Register the flags
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         data_ready <= 1'b0;
         armed <= 1'b0;
         scan_running_flag <= 1'b0;
      end else begin
         data_ready <= next_data_ready;
         armed <= next_armed;
         scan_running_flag <= next_scan_running_flag;
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   logic [15:0] next_reg_rdata;
   logic next_reg_ack;
   always_comb begin
      next_reg_rdata = 16'h0000;
      next_reg_ack = i_reg_sel;
      if (i_reg_sel && !i_reg_wr) begin
         case (sel)
            ADCRG_SEL_GSR: begin
               next_reg_rdata[`ADCRG_GSR_RDY_BIT] = data_ready;
               next_reg_rdata[`ADCRG_GSR_ARMED_BIT] = armed;
               next_reg_rdata[`ADCRG_GSR_RUN_BIT] = scan_running_flag;
               next_reg_rdata[`ADCRG_GSR_TEST_BIT] = selftest_off_flag;
            end
            ADCRG_SEL_PRE: next_reg_rdata = {8'h00, prescale_value};
            ADCRG_SEL_PER: next_reg_rdata = period_value;
            ADCRG_SEL_ICR: next_reg_rdata = {7'h00, irq_enable, irq_vector};
            ADCRG_SEL_ISR: next_reg_rdata = {13'h0000, irq_level};
            default: next_reg_rdata = 16'h0000;
         endcase
      end
   end

   // Register the read answer
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 16'h0000;
         o_reg_ack <= 1'b0;
      end else begin
         o_reg_rdata <= next_reg_rdata;
         o_reg_ack <= next_reg_ack;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt request and acknowledge
   // ----------------------------------------------------------------
   logic next_irq_req, next_iack_ack;
   logic [7:0] next_iack_vector;
   logic iack_hit;
   // Level 000 means the jumper disables the request line entirely
   always_comb begin
      next_irq_req = irq_enable && data_ready && (irq_level != 3'h0);
      iack_hit = i_iack_cycle && o_irq_req && (i_iack_level == o_irq_level);
      next_iack_ack = iack_hit;
      next_iack_vector = iack_hit ? irq_vector : 8'h00;
   end

   // Register the interrupt outputs
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_irq_req <= 1'b0;
         o_irq_level <= 3'h0;
         o_iack_ack <= 1'b0;
         o_iack_vector <= 8'h00;
      end else begin
         o_irq_req <= next_irq_req;
         o_irq_level <= irq_level;
         o_iack_ack <= next_iack_ack;
         o_iack_vector <= next_iack_vector;
      end
   end

   // ----------------------------------------------------------------
   // Sample clock generator
   // ----------------------------------------------------------------
   adcrg_rate_gen u_rate_gen (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .rate(rate.gen)
   );
   assign o_sample_tick = rate.sample_tick;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_rdy_event;
      !i_one_sample_buf && (i_half_full_select ? i_buf_half_evt : i_buf_full_evt);
   endsequence
   property p_rdy_set;
      @(posedge i_mclk) disable iff (i_sys_rst)
      s_rdy_event |=> data_ready ##1 (data_ready || $past(i_clear_flag_cmd));
   endproperty
   a_rdy_set: assert property (p_rdy_set) else $error("data ready not set");

   property p_rdy_clear;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clear_flag_cmd && !rdy_evt) |=> !data_ready;
   endproperty
   a_rdy_clear: assert property (p_rdy_clear) else $error("data ready not cleared");

   property p_one_sample;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (i_one_sample_buf && i_sample_stored) |=> data_ready;
   endproperty
   a_one_sample: assert property (p_one_sample) else $error("one-sample ready missed");

   property p_armed_drop;
      @(posedge i_mclk) disable iff (i_sys_rst)
      ((i_cfg_change || i_trigger) && !i_scan_arm) |=> !armed;
   endproperty
   a_armed_drop: assert property (p_armed_drop) else $error("armed not dropped");

   property p_run_cycle;
      @(posedge i_mclk) disable iff (i_sys_rst)
      i_trigger |=> (scan_running_flag && (!armed || $past(i_scan_arm)));
   endproperty
   a_run_cycle: assert property (p_run_cycle) else $error("running not raised");

   property p_run_drop;
      @(posedge i_mclk) disable iff (i_sys_rst)
      ((i_scan_done || i_abort_cmd) && !i_trigger) |=> !scan_running_flag;
   endproperty
   a_run_drop: assert property (p_run_drop) else $error("running not dropped");

   property p_test_bit;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (i_reg_sel && !i_reg_wr && sel == ADCRG_SEL_GSR)
      |=> (o_reg_rdata[`ADCRG_GSR_TEST_BIT] == $past(selftest_off_flag));
   endproperty
   a_test_bit: assert property (p_test_bit) else $error("test bit wrong");

   property p_irq_gate;
      @(posedge i_mclk) disable iff (i_sys_rst)
      !irq_enable |=> !o_irq_req;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");

   sequence s_iack_hit;
      i_iack_cycle && o_irq_req && (i_iack_level == o_irq_level);
   endsequence
   property p_iack_vector;
      @(posedge i_mclk) disable iff (i_sys_rst)
      s_iack_hit |=> (o_iack_ack && o_iack_vector == $past(irq_vector)) ##1 !o_iack_ack[*1];
   endproperty
   a_iack_vector: assert property (p_iack_vector) else $error("vector not returned");

   property p_level_read;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (i_reg_sel && !i_reg_wr && sel == ADCRG_SEL_ISR)
      |=> (o_reg_rdata == {13'h0000, $past(irq_level)});
   endproperty
   a_level_read: assert property (p_level_read) else $error("level read wrong");
endmodule // adcrg_regs

// ---- adcrg_host_model.sv ----
// Purpose: Host interrupt handler facing the ADC register block
// Assumes: Inputs sampled and outputs changed on the falling edge
// Notes:   i_wait stretches the answer so slow handlers are covered
`timescale 1ns/1ps
module adcrg_host_model (
   input wire logic i_mclk,
   input wire logic i_irq_req,
   input wire logic [2:0] i_irq_level,
   input wire logic i_iack_ack,
   input wire logic [7:0] i_iack_vector,
   input wire logic [3:0] i_wait,
   output logic o_iack_cycle,
   output logic [2:0] o_iack_level,
   output logic [7:0] o_vec,
   output int o_acks
);
   int k;
   // ----------------------------------------------------------------
   // Acknowledge once per request, then wait for it to drop
   // ----------------------------------------------------------------
   initial begin
      o_iack_cycle = 1'b0;
      o_iack_level = 3'h0;
      o_vec = 8'h00;
      o_acks = 0;
      forever begin
         @(negedge i_mclk);
         if (i_irq_req === 1'b1) begin
            repeat (i_wait) @(negedge i_mclk);
            o_iack_cycle = 1'b1;
            o_iack_level = i_irq_level;
            @(negedge i_mclk);
            o_iack_cycle = 1'b0;
            // Released level lines show the inverse, never a stale match
            o_iack_level = ~o_iack_level;
            if (i_iack_ack === 1'b1) begin
               o_vec = i_iack_vector;
               o_acks++;
            end
            k = 0;
            while (i_irq_req === 1'b1 && k < 64) begin
               @(negedge i_mclk);
               k++;
            end
         end
      end
   end
endmodule // adcrg_host_model

// ---- tb.sv ----
// Purpose: Self-checking bench for the ADC register block
// Assumes: Host model answers acknowledges; inputs change on falling edges
// Notes:   Status compare masks the fields this block does not own
`timescale 1ns/1ps
module tb;
   import adcrg_pkg::*;
   logic i_mclk, i_sys_rst, sel, wr, hfs, one, stoff, ack, irq, iack, tick, hack;
   logic [4:0] addr;
   logic [15:0] wd, rd;
   logic [8:0] ev;
   logic [2:0] lvl, olvl, ilvl;
   logic [7:0] vec, ivec, hvec;
   logic [3:0] hwait;
   logic rdy, armed, run;
   logic [7:0] pre;
   logic [15:0] per;
   logic [8:0] interrupt_control;
   int err_count, samples_checked, seed, n, i;
   int ofs[7] = '{6, 8, 10, 12, 14, 2, 30};
   int seq[19] = '{2, 3, 1, 0, 4, 5, 4, 6, 7, 6, 8, 9, 1, 3, 10, 0, 3, 9, 10};
   adcrg_regs adcrg_regs_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_sel(sel),
      .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rd), .o_reg_ack(ack),
      .i_half_full_select(hfs), .i_one_sample_buf(one), .i_sample_stored(ev[0]),
      .i_buf_half_evt(ev[1]), .i_buf_full_evt(ev[2]), .i_clear_flag_cmd(ev[3]),
      .i_scan_arm(ev[4]), .i_cfg_change(ev[5]), .i_trigger(ev[6]), .i_scan_done(ev[7]),
      .i_abort_cmd(ev[8]), .i_selftest_off_jmp(stoff), .i_irq_level_jmp(lvl),
      .i_iack_cycle(iack), .i_iack_level(ilvl), .o_irq_req(irq), .o_irq_level(olvl),
      .o_iack_ack(hack), .o_iack_vector(ivec), .o_sample_tick(tick));
   adcrg_host_model adcrg_host_model_i (.i_mclk(i_mclk), .i_irq_req(irq),
      .i_irq_level(olvl), .i_iack_ack(hack), .i_iack_vector(ivec), .i_wait(hwait),
      .o_iack_cycle(iack), .o_iack_level(ilvl), .o_vec(hvec), .o_acks(n));
   // ----------------------------------------------------------------
   // Clock, checks and bus tasks
   // ----------------------------------------------------------------
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] exp_rd(input logic [4:0] a);
      case (a)
         5'h06: return {8'h00, rdy, armed, run, 2'b00, stoff, 2'b00};
         5'h08: return {8'h00, pre};
         5'h0a: return per;
         5'h0c: return {7'h00, interrupt_control};
         5'h0e: return {13'h0000, lvl};
         default: return 16'h0000;
      endcase
   endfunction
   // One register cycle, compared with the model, then the model updated
   task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
      logic [15:0] e;
      e = w ? 16'h0000 : exp_rd(a);
      @(negedge i_mclk);
      sel = 1'b1;
      wr = w;
      addr = a;
      wd = d;
      @(negedge i_mclk);
      sel = 1'b0;
      chk({15'h0000, ack}, 16'h0001);
      chk((a == 5'h06) ? (rd & 16'h00e4) : rd, e);
      if (w && a == 5'h08) pre = d[7:0];
      if (w && a == 5'h0a) per = d;
      if (w && a == 5'h0c) interrupt_control = d[8:0];
   endtask
   // Event pulse or mode flip, with the status model following
   task automatic evp(input int b);
      if (b == 9) hfs = ~hfs;
      else if (b == 10) one = ~one;
      else begin
         @(negedge i_mclk);
         ev[b] = 1'b1;
         @(negedge i_mclk);
         ev = 9'h000;
         case (b)
            0: if (one) rdy = 1'b1;
            1: if (hfs && !one) rdy = 1'b1;
            2: if (!hfs && !one) rdy = 1'b1;
            3: rdy = 1'b0;
            4: armed = 1'b1;
            5: armed = 1'b0;
            6: begin armed = 1'b0; run = 1'b1; end
            default: run = 1'b0;
         endcase
      end
   endtask
   task automatic wait_tick(input int lim, output int c);
      c = 0;
      do begin
         @(negedge i_mclk);
         c++;
      end while (tick !== 1'b1 && c < lim);
      if (c >= lim) begin
         err_count++;
         complete_run();
      end
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int c, k0;
      {sel, wr, hfs, one, addr, wd, ev, err_count, samples_checked} = '0;
      {rdy, armed, run, pre, interrupt_control} = '0;
      per = 16'h03e7;
      seed = 32'h8b8e;
      stoff = 1'($random(seed));
      lvl = 3'(($unsigned($random(seed)) % 7) + 1);
      hwait = 4'($random(seed) & 7);
      i_sys_rst = 1'b1;
      repeat (12) @(negedge i_mclk);
      i_sys_rst = 1'b0;
      repeat (3) @(negedge i_mclk);
      for (i = 0; i < 7; i++) acc(1'b0, 5'(ofs[i]), 16'h0000);
      chk({13'h0000, olvl}, {13'h0000, lvl});
      acc(1'b1, 5'h0e, 16'hffff);
      acc(1'b1, 5'h06, 16'hffff);
      acc(1'b1, 5'h08, 16'($random(seed)) & 16'h00ff);
      acc(1'b1, 5'h0a, 16'($random(seed)) | 16'h00c8);
      for (i = 0; i < 7; i++) acc(1'b0, 5'(ofs[i]), 16'h0000);
      $display("test registers done");
      for (i = 0; i < 19; i++) begin
         evp(seq[i]);
         acc(1'b0, 5'h06, 16'h0000);
      end
      $display("test status done");
      vec = 8'($random(seed));
      acc(1'b1, 5'h0c, {8'h00, vec});
      evp(2);
      repeat (4) @(negedge i_mclk);
      chk({15'h0000, irq}, 16'h0000);
      k0 = n;
      acc(1'b1, 5'h0c, {7'h00, 1'b1, vec});
      c = 0;
      while (n == k0 && c < 40) begin
         @(negedge i_mclk);
         c++;
      end
      // No acknowledge within the bound is a failure in its own right
      if (n == k0) begin
         err_count++;
         complete_run();
      end
      chk({8'h00, hvec}, {8'h00, vec});
      chk({15'h0000, irq}, 16'h0001);
      evp(3);
      @(negedge i_mclk);
      chk({15'h0000, irq}, 16'h0000);
      // Jumper level 000 must hold the request off even when enabled
      lvl = 3'h0;
      evp(2);
      repeat (4) @(negedge i_mclk);
      chk({15'h0000, irq}, 16'h0000);
      acc(1'b0, 5'h0e, 16'h0000);
      evp(3);
      $display("test interrupt done");
      acc(1'b1, 5'h08, 16'h0001);
      acc(1'b1, 5'h0a, 16'd99);
      wait_tick(70000, c);
      for (i = 0; i < 2; i++) begin
         wait_tick(70000, c);
         chk(16'(c), 16'((int'(per) + 1) * (int'(pre) + 1) * 5));
      end
      $display("test sample clock done");
      complete_run();
   end
endmodule // tb
